// *** src/acc_ctrl.sv ***
// converter sample/convert sequencing, control register and module disable
// assumes trigger pins are asynchronous; core signals share sys_clk
//
// Behaviour
// - on bit 15 enables module operation
// - idle_halt stops module during idle mode
// - codes 7..4 select 32-bit result layouts
// - codes 3,2,0 select 16-bit layouts
// - trigger 111 auto-converts after internal count
// - trigger 011/010/001 use external events
// - trigger 000: writing acquire 0 converts
// - hardware clears acquire on selected trigger
// - halt_after_first_irq clears auto restart
// - otherwise sequences continue, result overwritten
// - auto restart resamples and sets acquire
// - software writes acquire 1 to sample
// - acquire reads 1 while sampling
// - done set when conversion finishes
// - software clears done; writing 1 ignored
// - done cleared at new conversion start
// - unimplemented control bits read zero
// - module disable bit stops converter clocks
// - writes ignored, reads invalid while disabled
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int SAMPLE_CYC = acc_pkg::AUTO_SAMPLE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [acc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic idle_mode,
    input wire logic ext_interrupt0,
    input wire logic timer3_match,
    input wire logic charge_time_unit_evt,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [acc_pkg::DATA_W-1:0] conv_data,
    output logic adc_clk_en,
    output logic sample_hold,
    output logic conv_irq
);
    import acc_pkg::*;

    typedef struct packed {
        logic on;
        logic idle_halt;
        logic [2:0] result_layout_sel;
        logic [2:0] trig;
        logic halt_irq;
        logic auto_acq;
        logic acq;
        logic done;
        logic pmd;
        acc_state_t st;
        logic [7:0] cnt;
        logic [2:0] ext_interrupt0_sync;
        logic [1:0] tmr_sync;
        logic [1:0] ctu_sync;
        logic [31:0] result;
        logic [31:0] rdata;
        logic start;
        logic clk_en;
        logic irq;
    } acc_state_s_t;

    acc_state_s_t cur_ff;
    acc_state_s_t nxt_s;

    ////////////////////////////////////////////////////////////////////////
    // result formatting
    function automatic logic [31:0] fmt_result(input logic [2:0] f,
                                               input logic [DATA_W-1:0] d);
        logic [31:0] r;
        logic [DATA_W-1:0] sd;
        r = 32'h0;
        sd = {~d[DATA_W-1], d[DATA_W-2:0]};
        case (f)
            FMT_SFRAC32: r = {sd, 22'h0};
            FMT_FRAC32: r = {d, 22'h0};
            FMT_SINT32: r = {{22{sd[DATA_W-1]}}, sd};
            FMT_INT32: r = {22'h0, d};
            FMT_SFRAC16: r = {16'h0, sd, 6'h0};
            FMT_FRAC16: r = {16'h0, d, 6'h0};
            FMT_INT16: r = {22'h0, d};
            default: r = {22'h0, d};
        endcase
        return r;
    endfunction

    logic run;
    logic trig_hit;
    logic ctrl_wr;
    logic [31:0] ctrl_rd;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s = cur_ff;
        // two flops before any logic sees the pins; third stage for edges
        nxt_s.ext_interrupt0_sync = {cur_ff.ext_interrupt0_sync[1:0], ext_interrupt0};
        nxt_s.tmr_sync = {cur_ff.tmr_sync[0], timer3_match};
        nxt_s.ctu_sync = {cur_ff.ctu_sync[0], charge_time_unit_evt};
        nxt_s.start = 1'b0;
        nxt_s.irq = 1'b0;
        run = cur_ff.on && !(cur_ff.idle_halt && idle_mode);
        nxt_s.clk_en = !cur_ff.pmd;
        ctrl_wr = reg_wr && reg_addr == OFF_CTRL && !cur_ff.pmd;
        ctrl_rd = {16'h0, cur_ff.on, 1'b0, cur_ff.idle_halt, 2'b00, cur_ff.result_layout_sel,
                   cur_ff.trig, cur_ff.halt_irq, 1'b0, cur_ff.auto_acq,
                   cur_ff.acq, cur_ff.done} & CTRL_MASK;

        if (reg_wr && reg_addr == OFF_PMD) begin
            nxt_s.pmd = reg_wdata[B_PMD_ADC];
        end
        if (ctrl_wr) begin
            nxt_s.on = reg_wdata[B_ON];
            nxt_s.idle_halt = reg_wdata[B_IDLE_HALT];
            nxt_s.result_layout_sel = reg_wdata[B_RESULT_LAYOUT_SEL_LO +: 3];
            nxt_s.trig = reg_wdata[B_TRIG_LO +: 3];
            nxt_s.halt_irq = reg_wdata[B_HALT_IRQ];
            nxt_s.auto_acq = reg_wdata[B_AUTO];
            if (!reg_wdata[B_DONE]) begin
                nxt_s.done = 1'b0;
            end
            if (reg_wdata[B_ACQ] && !cur_ff.acq && !cur_ff.auto_acq) begin
                nxt_s.acq = 1'b1;
            end else if (!reg_wdata[B_ACQ] && cur_ff.acq && cur_ff.trig == TRG_SOFT) begin
                nxt_s.acq = 1'b0;
            end
        end

        trig_hit = 1'b0;
        case (cur_ff.trig)
            TRG_EXT_INTERRUPT0: trig_hit = cur_ff.ext_interrupt0_sync[1] && !cur_ff.ext_interrupt0_sync[2];
            TRG_TMR3: trig_hit = cur_ff.tmr_sync[1];
            TRG_CTU: trig_hit = cur_ff.ctu_sync[1];
            TRG_AUTO: trig_hit = cur_ff.cnt == 8'(SAMPLE_CYC);
            default: trig_hit = 1'b0;
        endcase

        if (!run || cur_ff.pmd) begin
            nxt_s.st = ST_IDLE;
            nxt_s.cnt = 8'h0;
        end else begin
            case (cur_ff.st)
                ST_IDLE: begin
                    if (cur_ff.acq || cur_ff.auto_acq) begin
                        nxt_s.st = ST_SAMPLE;
                        nxt_s.acq = 1'b1;
                        nxt_s.cnt = 8'h0;
                    end
                end
                ST_SAMPLE: begin
                    nxt_s.cnt = cur_ff.cnt + 8'h1;
                    if (cur_ff.trig == TRG_SOFT ? !nxt_s.acq : trig_hit) begin
                        nxt_s.acq = 1'b0;
                        nxt_s.st = ST_CONVERT;
                        nxt_s.start = 1'b1;
                        nxt_s.done = 1'b0;
                    end else if (!cur_ff.acq && !cur_ff.auto_acq) begin
                        nxt_s.st = ST_IDLE;
                    end
                end
                ST_CONVERT: begin
                    if (conv_done) begin
                        nxt_s.done = 1'b1;
                        nxt_s.irq = 1'b1;
                        nxt_s.result = fmt_result(cur_ff.result_layout_sel, conv_data);
                        nxt_s.st = ST_IDLE;
                        if (cur_ff.halt_irq) begin
                            nxt_s.auto_acq = 1'b0;
                        end
                    end
                end
                default: nxt_s.st = ST_IDLE;
            endcase
        end

        nxt_s.rdata = 32'h0;
        if (reg_rd && !cur_ff.pmd) begin
            if (reg_addr == OFF_CTRL) begin
                nxt_s.rdata = ctrl_rd;
            end else if (reg_addr == OFF_RESULT) begin
                nxt_s.rdata = cur_ff.result;
            end
        end
        if (reg_rd && reg_addr == OFF_PMD) begin
            nxt_s.rdata = {31'h0, cur_ff.pmd};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_ff <= '0;
            cur_ff.clk_en <= 1'b1;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign reg_rdata = cur_ff.rdata;
    assign conv_start = cur_ff.start;
    assign adc_clk_en = cur_ff.clk_en;
    assign sample_hold = cur_ff.acq;
    assign conv_irq = cur_ff.irq;

    ////////////////////////////////////////////////////////////////////////
    property p_off_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        !cur_ff.on |=> cur_ff.st == ST_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("state active while off");

    property p_idle_halt;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.idle_halt && idle_mode) |=> !conv_start;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("start in idle halt");

    property p_start_clears_done;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start |-> !cur_ff.done && !cur_ff.acq;
    endproperty
    a_start_clears_done: assert property (p_start_clears_done) else $error("done/acq at start");

    property p_done_set;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.st == ST_CONVERT && conv_done && run && !cur_ff.pmd) |=> cur_ff.done && conv_irq;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");

    property p_halt_irq;
        @(posedge sys_clk) disable iff (!reset_n)
        (conv_irq && $past(cur_ff.halt_irq)) |-> !cur_ff.auto_acq;
    endproperty
    a_halt_irq: assert property (p_halt_irq) else $error("auto restart kept");

    property p_pmd_ignore;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.pmd && reg_wr && reg_addr == OFF_CTRL) |=> $stable(cur_ff.result_layout_sel);
    endproperty
    a_pmd_ignore: assert property (p_pmd_ignore) else $error("write while disabled");

    property p_clk_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        cur_ff.pmd |=> !adc_clk_en;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock not gated");

    property p_zero_bits;
        @(posedge sys_clk) disable iff (!reset_n)
        $past(reg_rd) && $past(reg_addr) == OFF_CTRL |-> (reg_rdata & ~CTRL_MASK) == 32'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bit set");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

    property p_pmd_read;
        @(posedge sys_clk) disable iff (!reset_n)
        ($past(reg_rd) && $past(cur_ff.pmd) && $past(reg_addr) == OFF_CTRL) |-> reg_rdata == 32'h0;
    endproperty
    a_pmd_read: assert property (p_pmd_read) else $error("control read while disabled");

    ////////////////////////////////////////////////////////////////////////
    // a completion that the running module accepts; restart checks build on it
    sequence s_conv_end;
        cur_ff.st == ST_CONVERT && conv_done && run && !cur_ff.pmd;
    endsequence

    sequence s_restart_armed;
        cur_ff.auto_acq && run && !cur_ff.pmd;
    endsequence

    property p_auto_restart;
        @(posedge sys_clk) disable iff (!reset_n)
        s_conv_end ##1 s_restart_armed |=> sample_hold;
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("no auto restart");

    property p_auto_start;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.st == ST_SAMPLE && cur_ff.trig == TRG_AUTO && cur_ff.cnt == 8'(SAMPLE_CYC)
            && run && !cur_ff.pmd) |=> conv_start;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("auto convert missed");

    property p_soft_start;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.st == ST_SAMPLE && cur_ff.trig == TRG_SOFT && cur_ff.acq && ctrl_wr
            && !reg_wdata[B_ACQ] && run && !cur_ff.pmd) |=> conv_start;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft convert missed");

    property p_hw_clear_acq;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.st == ST_SAMPLE && cur_ff.trig != TRG_SOFT && trig_hit && run && !cur_ff.pmd)
            |=> conv_start && !sample_hold;
    endproperty
    a_hw_clear_acq: assert property (p_hw_clear_acq) else $error("acquire not cleared");

    property p_ext_interrupt0_edge;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.st == ST_SAMPLE && cur_ff.trig == TRG_EXT_INTERRUPT0 && cur_ff.ext_interrupt0_sync[1]
            && !cur_ff.ext_interrupt0_sync[2] && run && !cur_ff.pmd) |=> conv_start;
    endproperty
    a_ext_interrupt0_edge: assert property (p_ext_interrupt0_edge) else $error("pin edge missed");

    property p_reserved_trig;
        @(posedge sys_clk) disable iff (!reset_n)
        (cur_ff.trig inside {3'h4, 3'h5, 3'h6}) |=> !conv_start;
    endproperty
    a_reserved_trig: assert property (p_reserved_trig) else $error("reserved source fired");

    property p_soft_sample;
        @(posedge sys_clk) disable iff (!reset_n)
        (ctrl_wr && reg_wdata[B_ACQ] && !cur_ff.acq && !cur_ff.auto_acq
            && cur_ff.st != ST_SAMPLE) |=> sample_hold;
    endproperty
    a_soft_sample: assert property (p_soft_sample) else $error("sampling not started");

    property p_done_sw_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        (ctrl_wr && !reg_wdata[B_DONE] && !(cur_ff.st == ST_CONVERT && conv_done))
            |=> !cur_ff.done;
    endproperty
    a_done_sw_clear: assert property (p_done_sw_clear) else $error("done not cleared");

    property p_done_no_sw_set;
        @(posedge sys_clk) disable iff (!reset_n)
        (ctrl_wr && reg_wdata[B_DONE] && !cur_ff.done && cur_ff.st != ST_CONVERT)
            |=> !cur_ff.done;
    endproperty
    a_done_no_sw_set: assert property (p_done_no_sw_set) else $error("done set by write");

    property p_pmd_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        cur_ff.pmd |=> cur_ff.st == ST_IDLE;
    endproperty
    a_pmd_idle: assert property (p_pmd_idle) else $error("active while disabled");

    property p_clk_on;
        @(posedge sys_clk) disable iff (!reset_n)
        !cur_ff.pmd |=> adc_clk_en;
    endproperty
    a_clk_on: assert property (p_clk_on) else $error("clock gated while enabled");

    property p_off_no_start;
        @(posedge sys_clk) disable iff (!reset_n)
        !run |=> !conv_start;
    endproperty
    a_off_no_start: assert property (p_off_no_start) else $error("start while stopped");

    property p_start_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    property p_irq_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_irq |=> !conv_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than one cycle");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (!reset_n)
        (conv_irq && !$past(cur_ff.result_layout_sel[2])) |-> cur_ff.result[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");

    property p_frac32_low;
        @(posedge sys_clk) disable iff (!reset_n)
        (conv_irq && $past(cur_ff.result_layout_sel) == FMT_FRAC32) |-> cur_ff.result[21:0] == 22'h0;
    endproperty
    a_frac32_low: assert property (p_frac32_low) else $error("low bits not zero");
endmodule

// *** common/acc_pkg.sv ***
// constants for the converter sample/convert control block
// assumes a plain register port with read data one cycle after the strobe
package acc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_PMD = 4'h4;
    localparam logic [3:0] OFF_RESULT = 4'h8;
    localparam int B_ON = 15;
    localparam int B_IDLE_HALT = 13;
    localparam int B_RESULT_LAYOUT_SEL_LO = 8;
    localparam int B_TRIG_LO = 5;
    localparam int B_HALT_IRQ = 4;
    localparam int B_AUTO = 2;
    localparam int B_ACQ = 1;
    localparam int B_DONE = 0;
    localparam int B_PMD_ADC = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_a7f7;
    localparam logic [31:0] PMD_RESET = 32'h0000_0000;
    localparam int DATA_W = 10;
    localparam int AUTO_SAMPLE_CYC = 31;
    typedef enum logic [2:0] {
        FMT_INT16 = 3'h0, FMT_FRAC16 = 3'h2, FMT_SFRAC16 = 3'h3,
        FMT_INT32 = 3'h4, FMT_SINT32 = 3'h5, FMT_FRAC32 = 3'h6, FMT_SFRAC32 = 3'h7
    } acc_fmt_t;
    typedef enum logic [2:0] {
        TRG_SOFT = 3'h0, TRG_EXT_INTERRUPT0 = 3'h1, TRG_TMR3 = 3'h2, TRG_CTU = 3'h3,
        TRG_AUTO = 3'h7
    } acc_trig_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_CONVERT = 2'b11
    } acc_state_t;
endpackage

// *** verif/acc_core_model.sv ***
// behavioural analog converter core facing the control block
// assumes conv_start is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module acc_core_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic conv_start,
    input wire logic adc_clk_en,
    input wire logic [7:0] lat,
    input wire logic [9:0] next_data,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [7:0] cnt;
    logic [9:0] val;
    // data is only valid beside the done pulse; otherwise show the inverse
    assign conv_data = conv_done ? val : ~val;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h0;
            conv_done <= 1'b0;
            val <= 10'h0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start && adc_clk_en) begin
                cnt <= lat;
                val <= next_data;
            end else if (cnt == 8'h1) begin
                cnt <= 8'h0;
                conv_done <= 1'b1;
            end else if (cnt != 8'h0) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the sample/convert control block
// assumes the core model answers each start after lat cycles
`timescale 1ns/1ps
module tb;
    import acc_pkg::*;
    logic sys_clk, reset_n, reg_wr, reg_rd, idle_mode, ext_interrupt0, timer3_match;
    logic charge_time_unit_evt, conv_start, conv_done, adc_clk_en, sample_hold, conv_irq, rd_q;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, lfsr, expq[$];
    logic [DATA_W-1:0] conv_data, next_data, last_data;
    logic [7:0] lat;
    logic [2:0] fl[7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] tl[4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    int mismatches, n_checks, n_start;
    acc_ctrl #(.SAMPLE_CYC(6)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .idle_mode(idle_mode), .ext_interrupt0(ext_interrupt0), .timer3_match(timer3_match),
        .charge_time_unit_evt(charge_time_unit_evt), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data), .adc_clk_en(adc_clk_en),
        .sample_hold(sample_hold), .conv_irq(conv_irq));
    acc_core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .conv_start(conv_start),
        .adc_clk_en(adc_clk_en), .lat(lat), .next_data(next_data), .conv_done(conv_done),
        .conv_data(conv_data));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fmt(logic [2:0] f, logic [9:0] d);
        logic [9:0] s;
        s = {~d[9], d[8:0]};
        case (f)
            3'h7: return {s, 22'h0};
            3'h6: return {d, 22'h0};
            3'h5: return {{22{s[9]}}, s};
            3'h3: return {16'h0, s, 6'h0};
            3'h2: return {16'h0, d, 6'h0};
            default: return {22'h0, d};
        endcase
    endfunction
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(logic w, logic r, logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            if (conv_irq === 1'b1) break;
        end
        chk({31'h0, conv_irq}, 32'h1);
    endtask
    // counts start pulses over a fixed span with the given setup
    task automatic try(logic [31:0] c, logic idl, int lo, int hi);
        idle_mode <= idl;
        #1 n_start = 0;
        bus(1'b1, 1'b0, OFF_CTRL, c);
        repeat (80) @(posedge sys_clk);
        chk({31'h0, n_start >= lo && n_start <= hi}, 32'h1);
        idle_mode <= 1'b0;
        repeat (20) @(posedge sys_clk);
        bus(1'b1, 1'b0, OFF_CTRL, 32'h0);
        // second write ends any sampling left over once the source is software again
        bus(1'b1, 1'b0, OFF_CTRL, 32'h0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        rd_q <= reg_rd;
        if (rd_q === 1'b1) chk(reg_rdata, expq.pop_front());
        if (conv_start === 1'b1) n_start++;
        if (conv_done === 1'b1) begin
            last_data = conv_data;
            next_data <= lfsr[9:0];
            lfsr <= lfsr_next(lfsr);
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results();
    end
    initial begin
        {reg_wr, reg_rd, idle_mode, ext_interrupt0, timer3_match, charge_time_unit_evt} = 6'h0;
        {reg_addr, reg_wdata, reset_n} = '0;
        lfsr = 32'hf3ec;
        next_data = 10'h2a5;
        lat = 8'd12;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk({31'h0, adc_clk_en}, 32'h1);
        rd(OFF_CTRL, CTRL_RESET);
        rd(OFF_PMD, PMD_RESET);
        rd(4'hc, 32'h0);
        bus(1'b1, 1'b0, OFF_CTRL, 32'hffff_7ff9);
        rd(OFF_CTRL, 32'h0000_27f0);
        $display("test reset and fields done");
        foreach (fl[i]) begin
            bus(1'b1, 1'b0, OFF_CTRL, 32'h8003 | {fl[i], 8'h0});
            @(posedge sys_clk);
            chk({31'h0, sample_hold}, 32'h1);
            bus(1'b1, 1'b0, OFF_CTRL, 32'h8001 | {fl[i], 8'h0});
            rd(OFF_CTRL, 32'h8000 | {fl[i], 8'h0});
            wait_irq();
            rd(OFF_RESULT, fmt(fl[i], last_data));
            rd(OFF_CTRL, 32'h8001 | {fl[i], 8'h0});
        end
        $display("test layouts done");
        lat <= 8'd2;
        foreach (tl[i]) begin
            bus(1'b1, 1'b0, OFF_CTRL, 32'h8002 | {tl[i], 5'h0});
            if (tl[i] != 3'h7) begin
                repeat (10) @(posedge sys_clk);
                chk({31'h0, sample_hold}, 32'h1);
            end
            @(posedge sys_clk);
            ext_interrupt0 <= (tl[i] == 3'h1);
            timer3_match <= (tl[i] == 3'h2);
            charge_time_unit_evt <= (tl[i] == 3'h3);
            @(posedge sys_clk);
            {timer3_match, charge_time_unit_evt} <= 2'b00;
            repeat (2) @(posedge sys_clk);
            ext_interrupt0 <= 1'b0;
            wait_irq();
            rd(OFF_CTRL, 32'h8001 | {tl[i], 5'h0});
        end
        bus(1'b1, 1'b0, OFF_CTRL, 32'h0);
        $display("test triggers done");
        try(32'h0000_00e2, 1'b0, 0, 0);
        try(32'h0000_a0e2, 1'b1, 0, 0);
        try(32'h0000_80e2, 1'b1, 1, 1);
        try(32'h0000_80f6, 1'b0, 1, 1);
        try(32'h0000_80e6, 1'b0, 2, 20);
        $display("test sequencing done");
        bus(1'b1, 1'b0, OFF_PMD, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, adc_clk_en}, 32'h0);
        bus(1'b1, 1'b0, OFF_CTRL, 32'h8000);
        rd(OFF_CTRL, 32'h0);
        bus(1'b1, 1'b0, OFF_PMD, 32'h0);
        rd(OFF_CTRL, 32'h0);
        chk({31'h0, adc_clk_en}, 32'h1);
        $display("test module disable done");
        repeat (3) @(posedge sys_clk);
        results();
    end
endmodule
